// ### verilog/smc_top.sv
// smc_top: sensor mode, range and clock configuration register bank
// holds trim readback, clock selection and the power/performance decode
// assumes a plain register port: one-cycle strobes, read data next cycle
`timescale 1ns/1ps

// Summary of operation
// - Z gain scaler reads as five low bits; value over four is gain.
// - trim register shows Y fine trim high nibble, Z low nibble.
// - low-noise path adds product of sample and trim, divided by 128.
// - with density stream on, no fine trim correction is applied.
// - rate code 0 to 8 divides external clock by 1 up to 24.
// - source code picks oscillator, master clock pin or bit clock pin.
// - clock register resets to zero: oscillator, no division.
// - mode register bits 7:6 pick 15, 30 or 60 g range.
// - mode register bit 5 turns on the density stream.
// - mode register bit 4 turns on the framed audio output.
// - mode field decodes standby, heart, ULTRA_LOW_POWER_MODE, VERY_LOW_POWER_MODE, LP, NARROW_BANDWIDTH_MODE, HP; low bits 1 on a low-noise code invalid.
// - dual codes run a low-noise path beside ULTRA_LOW_POWER_MODE or VERY_LOW_POWER_MODE; better feeds serial.
// - mode register resets to zero: standby, 15 g, both outputs off.
module smc_top import smc_pkg::*; #(
    parameter int SW = 16 // sample width
) (
    input wire logic ref_clk_in, // 50 MHz reference
    input wire logic resetn_in, // sync reset, low
    input wire logic ce_in, // clock enable, freezes state
    input wire logic [7:0] addr_in, // register address
    input wire logic [7:0] wdata_in, // write data
    input wire logic wr_in, // write strobe
    input wire logic rd_in, // read strobe
    output logic [7:0] rdata_out, // read data, cycle after strobe
    input wire logic [4:0] gain_scaler_z_in, // z gain trim value
    input wire logic [3:0] y_fine_trim_in, // y fine trim value
    input wire logic [3:0] z_fine_trim_in, // z fine trim value
    input wire logic osc_tick_in, // internal oscillator tick
    input wire logic mclk_in, // external master clock pin
    input wire logic bclk_in, // external bit clock pin
    output logic core_tick_out, // selected core clock tick
    output logic [1:0] clock_origin_select_out, // clock source code
    output logic [3:0] external_clock_divider_out, // rate code
    output logic [1:0] range_sel_out, // full-scale range code
    output logic density_stream_enable_out, // density output on
    output logic audio_frame_enable_out, // framed audio on
    output logic standby_out, // no path running
    output logic mode_invalid_out, // invalid mode code held
    output logic heart_sound_mode_out, // heart-sound path on
    output logic ultra_low_power_mode_out, // ULTRA_LOW_POWER_MODE path on
    output logic very_low_power_mode_out, // VERY_LOW_POWER_MODE path on
    output logic low_power_mode_out, // LP path on
    output logic narrow_bandwidth_mode_out, // NARROW_BANDWIDTH_MODE path on
    output logic high_performance_mode_out, // HP path on
    output logic low_noise_path_out, // LP, NARROW_BANDWIDTH_MODE or HP on
    output logic [SMC_NPATH-1:0] serial_path_out, // path feeding serial port
    input wire logic sample_valid_in, // sample strobe
    input wire logic signed [SW-1:0] x_sample_in, // x axis sample
    input wire logic signed [SW-1:0] y_sample_in, // y axis sample
    input wire logic signed [SW-1:0] z_sample_in, // z axis sample
    output logic sample_valid_out, // corrected sample strobe
    output logic signed [SW-1:0] x_sample_out, // x axis out
    output logic signed [SW-1:0] y_sample_out, // y axis out
    output logic signed [SW-1:0] z_sample_out // z axis out
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] clk_reg;
        logic [7:0] op_reg;
        logic [7:0] rdata;
        smc_mode_st_t st;
        logic [SMC_NPATH-1:0] path;
        logic [SMC_NPATH-1:0] serial;
    } smc_state_t;

    localparam smc_state_t SMC_STATE_RST = '{
        clk_reg: SMC_CLK_RST,
        op_reg: SMC_OP_RST,
        rdata: 8'h00,
        st: SMC_ST_STANDBY,
        path: '0,
        serial: '0
    };

    smc_state_t q, d;
    logic [SMC_NPATH:0] dec;
    logic apply_trim;

    // ----------------------------------------
    // helpers
    // ----------------------------------------

    // mode code to path vector; top bit flags an invalid code
    function automatic logic [SMC_NPATH:0] mode_decode(input logic [3:0] m);
        logic [SMC_NPATH:0] r;
        r = '0;
        unique case (m[3:2])
            SMC_MODE_STANDBY[3:2]: begin
                unique case (m[1:0])
                    SMC_MODE_HEART[1:0]: r[SMC_P_HEART] = 1'b1;
                    SMC_MODE_ULP[1:0]: r[SMC_P_ULP] = 1'b1;
                    SMC_MODE_VLP[1:0]: r[SMC_P_VLP] = 1'b1;
                    default: r = '0;
                endcase
            end
            SMC_MODE_LP[3:2]: r[SMC_P_LP] = 1'b1;
            SMC_MODE_RBW[3:2]: r[SMC_P_RBW] = 1'b1;
            default: r[SMC_P_HP] = 1'b1;
        endcase
        // low bits 2 or 3 of a low-noise code add a second path; low bits 1 flag the code invalid
        if (m[3:2] != SMC_MODE_STANDBY[3:2]) begin
            unique case (m[1:0])
                SMC_MODE_HEART[1:0]: r = {1'b1, {SMC_NPATH{1'b0}}};
                SMC_MODE_ULP[1:0]: r[SMC_P_ULP] = 1'b1;
                SMC_MODE_VLP[1:0]: r[SMC_P_VLP] = 1'b1;
                default: r = r;
            endcase
        end
        return r;
    endfunction : mode_decode

    // keep only the highest-performance path that is on
    function automatic logic [SMC_NPATH-1:0] top_path(input logic [SMC_NPATH-1:0] p);
        logic [SMC_NPATH-1:0] r;
        r = '0;
        for (int i = 0; i < SMC_NPATH; i++) begin
            if (p[i]) r = {{(SMC_NPATH-1){1'b0}}, 1'b1} << i;
        end
        return r;
    endfunction : top_path

    // read value of an address; unmapped reads zero
    function automatic logic [7:0] read_value(input logic [7:0] a, input smc_state_t s);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            SMC_ADDR_GAIN_Z: v = {3'h0, gain_scaler_z_in};
            SMC_ADDR_TRIM: v = {y_fine_trim_in, z_fine_trim_in};
            SMC_ADDR_CLK: v = s.clk_reg;
            SMC_ADDR_OP: v = s.op_reg;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : read_value

    // ----------------------------------------
    // next state
    // ----------------------------------------

    // register writes, read capture, mode decode
    always_comb begin
        d = q;
        d.rdata = 8'h00;
        if (wr_in && addr_in == SMC_ADDR_CLK) begin
            d.clk_reg = wdata_in & SMC_CLK_WMASK;
        end
        if (wr_in && addr_in == SMC_ADDR_OP) begin
            d.op_reg = wdata_in;
        end
        if (rd_in) begin
            d.rdata = read_value(addr_in, q);
        end
        dec = mode_decode(q.op_reg[SMC_MODE_LSB+:4]);
        d.path = dec[SMC_NPATH] ? '0 : dec[SMC_NPATH-1:0];
        d.serial = top_path(d.path);
        if (dec[SMC_NPATH]) d.st = SMC_ST_BAD;
        else if (dec[SMC_NPATH-1:0] == '0) d.st = SMC_ST_STANDBY;
        else d.st = SMC_ST_RUN;
    end

    // state register; reset wins over the enable
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) q <= SMC_STATE_RST;
        else if (ce_in) q <= d;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------

    // mode status from the one-hot state
    always_comb begin
        unique case (q.st)
            SMC_ST_STANDBY: begin
                standby_out = 1'b1;
                mode_invalid_out = 1'b0;
            end
            SMC_ST_RUN: begin
                standby_out = 1'b0;
                mode_invalid_out = 1'b0;
            end
            SMC_ST_BAD: begin
                standby_out = 1'b0;
                mode_invalid_out = 1'b1;
            end
            default: begin
                standby_out = 1'b0;
                mode_invalid_out = 1'b1;
            end
        endcase
    end

    // configuration fields
    assign rdata_out = q.rdata;
    assign clock_origin_select_out = q.clk_reg[SMC_SRC_LSB+:2];
    assign external_clock_divider_out = q.clk_reg[SMC_RATE_LSB+:4];
    assign range_sel_out = q.op_reg[SMC_RANGE_LSB+:2];
    assign density_stream_enable_out = q.op_reg[SMC_DENS_BIT];
    assign audio_frame_enable_out = q.op_reg[SMC_AUDIO_BIT];

    // path enables
    assign heart_sound_mode_out = q.path[SMC_P_HEART];
    assign ultra_low_power_mode_out = q.path[SMC_P_ULP];
    assign very_low_power_mode_out = q.path[SMC_P_VLP];
    assign low_power_mode_out = q.path[SMC_P_LP];
    assign narrow_bandwidth_mode_out = q.path[SMC_P_RBW];
    assign high_performance_mode_out = q.path[SMC_P_HP];
    assign low_noise_path_out = q.path[SMC_P_LP] | q.path[SMC_P_RBW] | q.path[SMC_P_HP];
    assign serial_path_out = q.serial;

    // ----------------------------------------
    // clock selection and sample correction
    // ----------------------------------------

    smc_clk_div u_clk_div (
        .ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .ce_in(ce_in),
        .src_in(q.clk_reg[SMC_SRC_LSB+:2]),
        .rate_in(q.clk_reg[SMC_RATE_LSB+:4]),
        .osc_tick_in(osc_tick_in),
        .mclk_in(mclk_in),
        .bclk_in(bclk_in),
        .tick_out(core_tick_out)
    );

    // trim only on the low-noise path, never on the density stream
    assign apply_trim = low_noise_path_out & ~q.op_reg[SMC_DENS_BIT];

    // x has no fine trim in this bank and passes through aligned
    smc_fine_trim #(.W(SW), .TW(4)) u_trim_x (
        .ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .ce_in(ce_in),
        .valid_in(sample_valid_in),
        .data_in(x_sample_in),
        .trim_in(4'h0),
        .apply_in(1'b0),
        .valid_out(sample_valid_out),
        .data_out(x_sample_out)
    );

    smc_fine_trim #(.W(SW), .TW(4)) u_trim_y (
        .ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .ce_in(ce_in),
        .valid_in(sample_valid_in),
        .data_in(y_sample_in),
        .trim_in(y_fine_trim_in),
        .apply_in(apply_trim),
        .valid_out(),
        .data_out(y_sample_out)
    );

    smc_fine_trim #(.W(SW), .TW(4)) u_trim_z (
        .ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .ce_in(ce_in),
        .valid_in(sample_valid_in),
        .data_in(z_sample_in),
        .trim_in(z_fine_trim_in),
        .apply_in(apply_trim),
        .valid_out(),
        .data_out(z_sample_out)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------

    sequence s_write_op(logic [3:0] code);
        ce_in && wr_in && addr_in == SMC_ADDR_OP && wdata_in[3:0] == code ##1 ce_in;
    endsequence

    sequence s_read(logic [7:0] a);
        ce_in && rd_in && addr_in == a;
    endsequence

    a_clk_reset_zero: assert property (@(posedge ref_clk_in)
        !resetn_in |=> q.clk_reg == 8'h00 && core_tick_out == osc_tick_in)
        else $error("clock register not cleared by reset");
    a_op_reset_zero: assert property (@(posedge ref_clk_in)
        !resetn_in |=> range_sel_out == SMC_RANGE_15G && !density_stream_enable_out
            && !audio_frame_enable_out && standby_out)
        else $error("mode register not cleared by reset");
    a_gain_read: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        s_read(SMC_ADDR_GAIN_Z) |=> rdata_out == {3'h0, $past(gain_scaler_z_in)})
        else $error("gain scaler readback wrong");
    a_trim_read: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        s_read(SMC_ADDR_TRIM) |=> rdata_out == {$past(y_fine_trim_in), $past(z_fine_trim_in)})
        else $error("fine trim readback wrong");
    a_reserved_zero: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        s_read(SMC_ADDR_CLK) |=> rdata_out[3:2] == 2'h0)
        else $error("reserved clock bits read nonzero");
    a_range_write: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        ce_in && wr_in && addr_in == SMC_ADDR_OP |=> range_sel_out == $past(wdata_in[7:6]))
        else $error("range not taken from write");
    a_density_bit: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        ce_in && wr_in && addr_in == SMC_ADDR_OP
            |=> density_stream_enable_out == $past(wdata_in[5]))
        else $error("density enable not taken from write");
    a_audio_bit: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        ce_in && wr_in && addr_in == SMC_ADDR_OP |=> audio_frame_enable_out == $past(wdata_in[4]))
        else $error("audio enable not taken from write");
    a_hp_decode: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        s_write_op(SMC_MODE_HP) |=> high_performance_mode_out && low_noise_path_out
            && !ultra_low_power_mode_out && !standby_out)
        else $error("high performance code not decoded");
    a_dual_serial: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        s_write_op(SMC_MODE_LP | SMC_MODE_ULP) |=> low_power_mode_out
            && ultra_low_power_mode_out && serial_path_out[SMC_P_LP])
        else $error("dual mode serial path wrong");
    a_invalid_mode: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        s_write_op(SMC_MODE_RBW | SMC_MODE_HEART) |=> mode_invalid_out && q.path == '0)
        else $error("invalid mode code not flagged");
    a_trim_gate: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        density_stream_enable_out |-> !apply_trim)
        else $error("trim applied to density stream");
endmodule : smc_top

// ### verilog/smc_pkg.sv
// smc_pkg: offsets, fields, codes and types of the sensor mode/clock bank
// assumes an 8-bit register port and a single 50 MHz reference clock
package smc_pkg;

    // register offsets
    localparam logic [7:0] SMC_ADDR_GAIN_Z = 8'h21;
    localparam logic [7:0] SMC_ADDR_TRIM = 8'h24;
    localparam logic [7:0] SMC_ADDR_CLK = 8'h25;
    localparam logic [7:0] SMC_ADDR_OP = 8'h26;

    // reset values and writable bits
    localparam logic [7:0] SMC_CLK_RST = 8'h00;
    localparam logic [7:0] SMC_OP_RST = 8'h00;
    localparam logic [7:0] SMC_CLK_WMASK = 8'hf3;

    // field positions
    localparam int SMC_RATE_LSB = 4;
    localparam int SMC_SRC_LSB = 0;
    localparam int SMC_RANGE_LSB = 6;
    localparam int SMC_DENS_BIT = 5;
    localparam int SMC_AUDIO_BIT = 4;
    localparam int SMC_MODE_LSB = 0;
    localparam int SMC_YTRIM_LSB = 4;
    localparam int SMC_ZTRIM_LSB = 0;
    localparam int SMC_TRIM_SHIFT = 7;

    // clock source codes
    localparam logic [1:0] SMC_SRC_OSC = 2'h0;
    localparam logic [1:0] SMC_SRC_MCLK = 2'h1;
    localparam logic [1:0] SMC_SRC_BCLK = 2'h2;

    // full-scale range codes
    localparam logic [1:0] SMC_RANGE_15G = 2'h0;
    localparam logic [1:0] SMC_RANGE_30G = 2'h1;
    localparam logic [1:0] SMC_RANGE_60G = 2'h2;

    // operating-mode codes
    localparam logic [3:0] SMC_MODE_STANDBY = 4'h0;
    localparam logic [3:0] SMC_MODE_HEART = 4'h1;
    localparam logic [3:0] SMC_MODE_ULP = 4'h2;
    localparam logic [3:0] SMC_MODE_VLP = 4'h3;
    localparam logic [3:0] SMC_MODE_LP = 4'h4;
    localparam logic [3:0] SMC_MODE_RBW = 4'h8;
    localparam logic [3:0] SMC_MODE_HP = 4'hc;

    // path vector bit positions, lowest performance first
    localparam int SMC_P_HEART = 0;
    localparam int SMC_P_ULP = 1;
    localparam int SMC_P_VLP = 2;
    localparam int SMC_P_LP = 3;
    localparam int SMC_P_RBW = 4;
    localparam int SMC_P_HP = 5;
    localparam int SMC_NPATH = 6;

    typedef enum logic [2:0] {
        SMC_ST_STANDBY = 3'b001,
        SMC_ST_RUN = 3'b010,
        SMC_ST_BAD = 3'b100
    } smc_mode_st_t;

    // external clock division ratio for a rate code
    function automatic logic [4:0] smc_div_ratio(input logic [3:0] rate);
        case (rate)
            4'h1: smc_div_ratio = 5'h02;
            4'h2: smc_div_ratio = 5'h03;
            4'h3: smc_div_ratio = 5'h04;
            4'h4: smc_div_ratio = 5'h06;
            4'h5: smc_div_ratio = 5'h08;
            4'h6: smc_div_ratio = 5'h0c;
            4'h7: smc_div_ratio = 5'h10;
            4'h8: smc_div_ratio = 5'h18;
            default: smc_div_ratio = 5'h01;
        endcase
    endfunction : smc_div_ratio

endpackage : smc_pkg

// ### verilog/smc_clk_div.sv
// smc_clk_div: picks the core clock tick and divides an external clock
// assumes clock pins are sampled as synchronous levels of ref_clk_in
`timescale 1ns/1ps
module smc_clk_div import smc_pkg::*; (
    input wire logic ref_clk_in, // 50 MHz reference
    input wire logic resetn_in, // sync reset, low
    input wire logic ce_in, // clock enable
    input wire logic [1:0] src_in, // clock source code
    input wire logic [3:0] rate_in, // divider rate code
    input wire logic osc_tick_in, // internal oscillator tick
    input wire logic mclk_in, // external master clock level
    input wire logic bclk_in, // external bit clock level
    output logic tick_out // core clock tick
);
    typedef struct packed {
        logic prev;
        logic [4:0] cnt;
        logic tick;
    } smc_div_st_t;

    smc_div_st_t q, d;
    logic pin, rise;
    logic [4:0] last;

    // edge detect and divide
    always_comb begin
        pin = (src_in == SMC_SRC_MCLK) ? mclk_in : bclk_in;
        rise = pin & ~q.prev;
        last = smc_div_ratio(rate_in) - 5'h01;
        d = q;
        d.prev = pin;
        d.tick = 1'b0;
        if (rise) begin
            if (q.cnt >= last) begin
                d.cnt = 5'h00;
                d.tick = 1'b1;
            end else begin
                d.cnt = q.cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) q <= '0;
        else if (ce_in) q <= d;
    end

    // oscillator passes straight, external paths divided
    assign tick_out = (src_in == SMC_SRC_OSC) ? osc_tick_in : q.tick;

    a_div_count: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        ce_in && rise && q.cnt < last |=> !q.tick && q.cnt == $past(q.cnt) + 5'h01)
        else $error("divider count did not advance");
    a_div_wrap: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        ce_in && rise && q.cnt >= last |=> q.tick && q.cnt == 5'h00)
        else $error("divider did not tick at ratio");
    a_src_osc: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        src_in == SMC_SRC_OSC |-> tick_out == osc_tick_in)
        else $error("oscillator tick not selected");
endmodule : smc_clk_div

// ### verilog/smc_fine_trim.sv
// smc_fine_trim: one axis of fine sensitivity correction, registered
// assumes samples arrive as one-cycle valid strobes
`timescale 1ns/1ps
module smc_fine_trim import smc_pkg::*; #(
    parameter int W = 16,
    parameter int TW = 4
) (
    input wire logic ref_clk_in, // 50 MHz reference
    input wire logic resetn_in, // sync reset, low
    input wire logic ce_in, // clock enable
    input wire logic valid_in, // sample strobe
    input wire logic signed [W-1:0] data_in, // raw sample
    input wire logic [TW-1:0] trim_in, // unsigned fine trim
    input wire logic apply_in, // apply correction
    output logic valid_out, // corrected strobe
    output logic signed [W-1:0] data_out // corrected sample
);
    typedef struct packed {
        logic valid;
        logic signed [W-1:0] data;
    } smc_trim_st_t;

    smc_trim_st_t q, d;

    // x + (x*trim)/128, saturated to W bits
    function automatic logic signed [W-1:0] trim_calc(input logic signed [W-1:0] x,
            input logic [TW-1:0] t);
        logic signed [W+TW:0] p;
        logic signed [W+TW:0] s;
        p = x * $signed({1'b0, t});
        s = (p >>> SMC_TRIM_SHIFT) + x;
        if (s[W+TW:W-1] != {(TW+2){s[W+TW]}}) trim_calc = {s[W+TW], {(W-1){~s[W+TW]}}};
        else trim_calc = s[W-1:0];
    endfunction : trim_calc

    always_comb begin
        d = q;
        d.valid = valid_in;
        if (valid_in) d.data = apply_in ? trim_calc(data_in, trim_in) : data_in;
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) q <= '0;
        else if (ce_in) q <= d;
    end

    assign valid_out = q.valid;
    assign data_out = q.data;

    a_trim_apply: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        ce_in && valid_in && apply_in |=> data_out == trim_calc($past(data_in), $past(trim_in)))
        else $error("fine trim result wrong");
    a_trim_bypass: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        ce_in && valid_in && !apply_in |=> data_out == $past(data_in))
        else $error("sample altered while bypassed");
endmodule : smc_fine_trim

// ### test/smc_top_bench.sv
// smc_top_bench: self-checking bench for the sensor mode and clock bank
// assumes smc_top as declared in verilog/, driven directly with no partner model
`timescale 1ns/1ps
module smc_top_bench import smc_pkg::*;;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic ref_clk_in = 1'b0, resetn_in = 1'b0, ce_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
    logic osc_tick_in = 1'b0, mclk_in = 1'b0, bclk_in = 1'b0, vld = 1'b0;
    logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out;
    logic [4:0] gain = 5'h00;
    logic [3:0] yt = 4'h0, zt = 4'h0, div;
    logic signed [15:0] xs = 16'h0000, ys = 16'h0000, zs = 16'h0000, xo, yo, zo;
    logic tick, dens, aud, sb, inv, lnp, vo;
    logic [1:0] org, rng;
    logic [5:0] pth, ser;
    int miscompares = 0;
    int num_checks = 0;

    // free-running 50 MHz clock
    always #10 ref_clk_in = ~ref_clk_in;

    smc_top u_smc_top (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .gain_scaler_z_in(gain), .y_fine_trim_in(yt),
        .z_fine_trim_in(zt), .osc_tick_in(osc_tick_in), .mclk_in(mclk_in), .bclk_in(bclk_in),
        .core_tick_out(tick), .clock_origin_select_out(org),
        .external_clock_divider_out(div), .range_sel_out(rng),
        .density_stream_enable_out(dens), .audio_frame_enable_out(aud), .standby_out(sb),
        .mode_invalid_out(inv), .heart_sound_mode_out(pth[0]),
        .ultra_low_power_mode_out(pth[1]), .very_low_power_mode_out(pth[2]),
        .low_power_mode_out(pth[3]), .narrow_bandwidth_mode_out(pth[4]),
        .high_performance_mode_out(pth[5]), .low_noise_path_out(lnp),
        .serial_path_out(ser), .sample_valid_in(vld), .x_sample_in(xs), .y_sample_in(ys),
        .z_sample_in(zs), .sample_valid_out(vo), .x_sample_out(xo), .y_sample_out(yo),
        .z_sample_out(zo));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        if (miscompares == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    // reset for 16 cycles, released on an edge
    task automatic rst();
        @(posedge ref_clk_in);
        resetn_in <= 1'b0;
        repeat (16) @(posedge ref_clk_in);
        resetn_in <= 1'b1;
    endtask : rst

    // write, then wait for the decode that lags one cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
        @(posedge ref_clk_in);
        #1;
    endtask : wr

    // read: data in the cycle after the strobe only
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        #1 chk(rdata_out, e);
        @(posedge ref_clk_in);
        #1 chk(rdata_out, 8'h00);
    endtask : rd

    task automatic samp(input logic [15:0] x, input logic [15:0] ey, input logic [15:0] ez);
        @(posedge ref_clk_in);
        vld <= 1'b1;
        xs <= x;
        ys <= x;
        zs <= x;
        @(posedge ref_clk_in);
        vld <= 1'b0;
        #1 chk({15'h0000, vo}, 16'h0001);
        chk(xo, x);
        chk(yo, ey);
        chk(zo, ez);
    endtask : samp

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        @(posedge ref_clk_in);
        gain <= 5'h1b;
        yt <= 4'ha;
        zt <= 4'h5;
        osc_tick_in <= 1'b1;
        #1 chk({15'h0000, tick}, 16'h0001);
        rd(8'h25, 8'h00);
        rd(8'h26, 8'h00);
        chk({sb, inv, pth, rng, dens, aud}, {1'b1, 11'h000});
        wr(8'h21, 8'hff);
        wr(8'h24, 8'h00);
        wr(8'h22, 8'h55);
        rd(8'h21, 8'h1b);
        rd(8'h24, 8'ha5);
        rd(8'h22, 8'h00);
        wr(8'h25, 8'h8d);
        rd(8'h25, 8'h81);
        chk({org, div}, 6'h18);
        @(posedge ref_clk_in);
        ce_in <= 1'b0;
        wr(8'h25, 8'h00);
        @(posedge ref_clk_in);
        ce_in <= 1'b1;
        rd(8'h25, 8'h81);
    endtask : t_regs

    // every mode code with varied range and output enables
    task automatic t_modes();
        logic [7:0] v;
        logic [5:0] p;
        logic [5:0] s;
        for (int m = 0; m < 16; m++) begin
            v = {2'(m % 3), m[0], m[1], 4'(m)};
            p = 6'h00;
            if (v[3:2] == 2'h0) begin
                if (v[1:0] != 2'h0) p[v[1:0] - 1] = 1'b1;
            end else begin
                if (v[1:0] != 2'h1) p[v[3:2] + 2] = 1'b1;
                if (v[1]) p[v[1:0] - 1] = 1'b1;
            end
            s = (v[3:2] == 2'h0) ? p : p & 6'h38;
            wr(8'h26, v);
            chk({rng, dens, aud}, v[7:4]);
            chk({sb, inv, pth}, {v[3:0] == 4'h0, v[3:2] != 2'h0 && v[1:0] == 2'h1, p});
            chk({lnp, ser}, {|p[5:3], s});
            rd(8'h26, v);
        end
    endtask : t_modes

    task automatic t_trim();
        wr(8'h26, 8'h0c);
        @(posedge ref_clk_in);
        yt <= 4'hf;
        zt <= 4'h3;
        rd(8'h24, 8'hf3);
        samp(16'h1000, 16'h11e0, 16'h1060);
        samp(16'hf000, 16'hee20, 16'hefa0);
        samp(16'h7f00, 16'h7fff, 16'h7fff);
        samp(16'h8100, 16'h8000, 16'h8000);
        wr(8'h26, 8'h2c);
        samp(16'h1000, 16'h1000, 16'h1000);
        wr(8'h26, 8'h02);
        samp(16'h1000, 16'h1000, 16'h1000);
    endtask : t_trim

    // 48 rising edges of master or bit clock per rate code, counting core ticks
    task automatic t_div();
        int r[9] = '{1, 2, 3, 4, 6, 8, 12, 16, 24};
        int n;
        for (int c = 0; c < 9; c++) begin
            rst();
            wr(8'h25, {4'(c), c[0] ? 4'h2 : 4'h1});
            n = 0;
            for (int i = 0; i < 102; i++) begin
                @(posedge ref_clk_in);
                if (i < 96 && c[0]) bclk_in <= ~bclk_in;
                else if (i < 96) mclk_in <= ~mclk_in;
                #1 n += (tick === 1'b1);
            end
            chk(16'(n), 16'(48 / r[c]));
        end
    endtask : t_div

    // main sequence
    initial begin
        rst();
        t_regs();
        t_modes();
        t_trim();
        t_div();
        stop_test();
    end
endmodule : smc_top_bench
